/* design/ssc_pkg.sv */
// package: register map, field layout, reset values and types of the serial channel
package ssc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CTRL0 = 8'h04;
    localparam logic [7:0] OFS_CTRL1 = 8'h08;
    localparam logic [7:0] OFS_BRG = 8'h0C;
    localparam logic [7:0] OFS_TXBUF = 8'h10;
    localparam logic [7:0] OFS_RXBUF = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // mode register fields
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_EXT_CLK = 3;
    localparam logic [2:0] MODE_SYNC = 3'h1;
    // control 0 fields
    localparam int C0_SRC_LSB = 0;
    localparam int C0_RTS_SEL = 2;
    localparam int C0_HS_DIS = 4;
    localparam int C0_POL = 6;
    localparam int C0_MSB = 7;
    // control 1 fields
    localparam int C1_TX_EN = 0;
    localparam int C1_RX_EN = 2;
    localparam int C1_TX_CAUSE = 4;
    localparam int C1_CONT_RX = 5;
    localparam int C1_MULTI_CLK = 6;
    localparam int C1_CLK_PIN_SEL = 7;
    localparam int C1_SEP_HS = 8;
    // status fields and receive buffer overrun bit
    localparam int ST_RX_FULL = 0;
    localparam int ST_TX_EMPTY = 1;
    localparam int ST_TX_IDLE = 2;
    localparam int ST_OVERRUN = 3;
    localparam int ST_COLL = 4;
    localparam int RX_OVERRUN = 8;
    // count source select codes and prescale wrap values
    localparam logic [1:0] SRC_F1 = 2'h0;
    localparam logic [1:0] SRC_F8 = 2'h1;
    localparam logic [1:0] SRC_F32 = 2'h2;
    localparam logic [4:0] PRE_F8_WRAP = 5'h07;
    localparam logic [4:0] PRE_F32_WRAP = 5'h1F;
    // reset value, dummy transmit byte and last bit index
    localparam logic [7:0] RST_BRG = 8'h00;
    localparam logic [7:0] DUMMY_BYTE = 8'hFF;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [0:0] {
        SSC_IDLE = 1'b0,
        SSC_SHIFT = 1'b1
    } ssc_fsm_type;

    typedef struct packed {
        logic [2:0] mode;
        logic ext_clk;
        logic [1:0] src_sel;
        logic rts_sel;
        logic hs_dis;
        logic pol;
        logic msb;
        logic tx_en;
        logic rx_en;
        logic tx_cause;
        logic cont_rx;
        logic multi_clk;
        logic clk_pin_sel;
        logic sep_hs;
        logic [7:0] brg;
        logic [7:0] txbuf;
        logic tx_empty;
        logic [7:0] rxbuf;
        logic rx_full;
        logic overrun;
        logic coll_flag;
        logic rearm;
        ssc_fsm_type fsm;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic rx_act;
        logic [2:0] bitcnt;
        logic [4:0] pre_cnt;
        logic [7:0] brg_cnt;
        logic clk_lvl;
        logic clk_in_prev;
        logic txd;
        logic clk_out;
        logic clk_oe;
        logic clk2_out;
        logic clk2_oe;
        logic hs_out;
        logic hs_oe;
        logic hs2_out;
        logic hs2_oe;
        logic tx_irq;
        logic rx_irq;
        logic coll_irq;
        logic coll_prev;
        logic ack;
        logic [31:0] dat;
    } ssc_state_type;
endpackage

/* design/ssc_channel.sv */
// clock-synchronous serial channel with wishbone register slave
// Operation
// [R1] each channel has its own bit rate timer, independent of others
// [R2] three-bit mode field selects synchronous serial or asynchronous operation
// [R3] third channel flags a collision when transmit and receive pin levels differ
// [R4] third channel never runs the synchronous mode
// [R5] every synchronous transfer moves eight bits each way
// [R6] internal clock rate is prescaled clock over twice bit rate value plus one
// [R7] internal clock source drives the transfer clock out on the clock pin
// [R8] external clock source shifts data on the clock from the pin
// [R9] transmit starts with enable set, buffer loaded and clear-to-send low if used
// [R10] peer holds external clock at the idle level before a transfer
// [R11] receive needs receive enable plus the transmit start conditions
// [R12] transmit request at buffer-to-shifter move or at shift completion, by cause bit
// [R13] receive request when a byte moves into the receive buffer
// [R14] unread buffer at completion: overrun flagged, buffer overwritten, no request
// [R15] polarity chooses which clock edge changes data and which samples it
// [R16] bit order chooses bit 0 first or bit 7 first
// [R17] continuous receive: buffer read restarts reception without a dummy write
// [R18] second channel may output its clock on either of two pins
// [R19] first channel may split clear-to-send and request-to-send onto two pins
// [R20] handshake is clear-to-send input, request-to-send output, or disabled
// [R21] transmit pin stays high from mode selection until first transfer
// [R22] bit order value 0 means lsb first, 1 means msb first
// [R23] internal clock toggles only during the eight bit times, idle otherwise
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ns
module ssc_channel #(
    parameter int CHANNEL = 0
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic txd_out,
    input wire logic rxd_in,
    input wire logic clk_pin_in,
    output logic clk_pin_out,
    output logic clk_pin_oe,
    output logic clk2_pin_out,
    output logic clk2_pin_oe,
    input wire logic hs_pin_in,
    output logic hs_pin_out,
    output logic hs_pin_oe,
    input wire logic hs2_pin_in,
    output logic hs2_pin_out,
    output logic hs2_pin_oe,
    output logic tx_irq,
    output logic rx_irq,
    output logic coll_irq
);
    ssc_pkg::ssc_state_type q, n;

    logic sync_on;
    logic idle_lvl;
    logic tick;
    logic multi_on;
    logic sep_on;
    logic cts_used;
    logic cts_ok;
    logic can_start;
    logic edge_ev;
    logic new_lvl;
    logic out_bit;
    logic [7:0] rx_next;
    logic bus_req;
    logic wr;
    logic rd;
    logic mismatch;
    logic [31:0] rd_data;

    always_comb
    begin
        n = q;
        n.tx_irq = 1'b0;
        n.rx_irq = 1'b0;
        n.coll_irq = 1'b0;
        rd_data = 32'h0000_0000;

        // mode decode; third channel has no synchronous mode
        sync_on = (q.mode == ssc_pkg::MODE_SYNC) && (CHANNEL != 2); // [R2] [R4]
        idle_lvl = ~q.pol;
        multi_on = (CHANNEL == 1) && q.multi_clk && !q.ext_clk; // [R18]
        sep_on = (CHANNEL == 0) && q.sep_hs; // [R19]

        // prescaler producing f1, f8, f32 ticks
        n.pre_cnt = q.pre_cnt + 5'h1;
        case (q.src_sel)
            ssc_pkg::SRC_F1: tick = 1'b1;
            ssc_pkg::SRC_F8: tick = (q.pre_cnt[2:0] == ssc_pkg::PRE_F8_WRAP[2:0]);
            ssc_pkg::SRC_F32: tick = (q.pre_cnt == ssc_pkg::PRE_F32_WRAP);
            default: tick = 1'b1;
        endcase

        // handshake selection
        cts_used = sep_on || (!q.hs_dis && !q.rts_sel && !multi_on); // [R20]
        cts_ok = !cts_used || !hs_pin_in; // [R9]
        if (sep_on)
        begin
            n.hs_oe = 1'b0;
            n.hs_out = 1'b1;
            n.hs2_oe = 1'b1; // [R19]
            n.hs2_out = !(q.rx_en && !q.rx_full);
        end
        else
        begin
            n.hs_oe = !q.hs_dis && q.rts_sel && !multi_on; // [R20]
            n.hs_out = !(q.rx_en && !q.rx_full);
            n.hs2_oe = 1'b0;
            n.hs2_out = 1'b1;
        end

        // start: enable, data or rearm, handshake, external clock at idle
        can_start = sync_on && q.tx_en && (!q.tx_empty || q.rearm) && cts_ok
            && (!q.ext_clk || (clk_pin_in == idle_lvl)); // [R9] [R10] [R11]

        // clock edge events
        n.clk_in_prev = clk_pin_in;
        edge_ev = 1'b0;
        new_lvl = q.clk_lvl;
        out_bit = q.msb ? q.tx_sh[7] : q.tx_sh[0]; // [R16] [R22]
        rx_next = q.msb ? {q.rx_sh[6:0], rxd_in} : {rxd_in, q.rx_sh[7:1]}; // [R16]

        case (q.fsm)
            ssc_pkg::SSC_IDLE:
            begin
                n.clk_lvl = idle_lvl; // [R23]
                n.brg_cnt = q.brg;
                if (!sync_on)
                begin
                    n.txd = 1'b1; // [R21]
                end
                if (can_start)
                begin
                    n.fsm = ssc_pkg::SSC_SHIFT;
                    n.bitcnt = 3'h0;
                    n.rx_act = q.rx_en; // [R11]
                    n.rearm = 1'b0;
                    if (!q.tx_empty)
                    begin
                        n.tx_sh = q.txbuf;
                        n.tx_empty = 1'b1;
                        n.tx_irq = !q.tx_cause; // [R12]
                    end
                    else
                    begin
                        n.tx_sh = ssc_pkg::DUMMY_BYTE; // [R17]
                    end
                end
            end
            ssc_pkg::SSC_SHIFT:
            begin
                if (q.ext_clk)
                begin
                    edge_ev = (clk_pin_in != q.clk_in_prev); // [R8]
                    new_lvl = clk_pin_in;
                end
                else if (tick)
                begin
                    if (q.brg_cnt == 8'h00)
                    begin
                        n.brg_cnt = q.brg; // [R1] [R6]
                        edge_ev = 1'b1;
                        new_lvl = ~q.clk_lvl;
                        n.clk_lvl = new_lvl; // [R23]
                    end
                    else
                    begin
                        n.brg_cnt = q.brg_cnt - 8'h01; // [R6]
                    end
                end
                if (edge_ev && (new_lvl != idle_lvl))
                begin
                    n.txd = out_bit; // [R15]
                    n.tx_sh = q.msb ? {q.tx_sh[6:0], 1'b1} : {1'b1, q.tx_sh[7:1]};
                end
                else if (edge_ev)
                begin
                    n.rx_sh = rx_next; // [R15]
                    n.bitcnt = q.bitcnt + 3'h1;
                    if (q.bitcnt == ssc_pkg::LAST_BIT)
                    begin
                        n.fsm = ssc_pkg::SSC_IDLE; // [R5]
                        n.tx_irq = q.tx_cause; // [R12]
                        if (q.rx_act)
                        begin
                            n.rxbuf = rx_next;
                            if (q.rx_full)
                            begin
                                n.overrun = 1'b1; // [R14]
                            end
                            else
                            begin
                                n.rx_irq = 1'b1; // [R13]
                            end
                        end
                    end
                end
                if (!sync_on)
                begin
                    n.fsm = ssc_pkg::SSC_IDLE;
                end
            end
            default:
            begin
                n.fsm = ssc_pkg::SSC_IDLE;
            end
        endcase

        // clock pins: driven only for internal clock
        n.clk_oe = sync_on && !q.ext_clk && !(multi_on && q.clk_pin_sel); // [R7] [R18]
        n.clk2_oe = sync_on && multi_on && q.clk_pin_sel; // [R18]
        n.clk_out = n.clk_lvl;
        n.clk2_out = n.clk_lvl;

        // collision detection on the third channel
        mismatch = (CHANNEL == 2) && (q.mode != 3'h0) && (q.txd != rxd_in); // [R3]
        n.coll_prev = mismatch;
        n.coll_irq = mismatch && !q.coll_prev; // [R3]

        // wishbone slave, one wait state
        bus_req = wb_cyc_i && wb_stb_i && !q.ack;
        wr = bus_req && wb_we_i;
        rd = bus_req && !wb_we_i;
        n.ack = bus_req;
        case (wb_adr_i)
            ssc_pkg::OFS_MODE: rd_data = {28'h000_0000, q.ext_clk, q.mode};
            ssc_pkg::OFS_CTRL0: rd_data = {24'h00_0000, q.msb, q.pol, 1'b0, q.hs_dis,
                1'b0, q.rts_sel, q.src_sel};
            ssc_pkg::OFS_CTRL1: rd_data = {23'h00_0000, q.sep_hs, q.clk_pin_sel,
                q.multi_clk, q.cont_rx, q.tx_cause, 1'b0, q.rx_en, 1'b0, q.tx_en};
            ssc_pkg::OFS_BRG: rd_data = {24'h00_0000, q.brg};
            ssc_pkg::OFS_TXBUF: rd_data = {24'h00_0000, q.txbuf};
            ssc_pkg::OFS_RXBUF: rd_data = {23'h00_0000, q.overrun, q.rxbuf};
            ssc_pkg::OFS_STATUS: rd_data = {27'h000_0000, q.coll_flag, q.overrun,
                (q.fsm == ssc_pkg::SSC_IDLE), q.tx_empty, q.rx_full};
            default: rd_data = 32'h0000_0000;
        endcase
        if (rd)
        begin
            n.dat = rd_data;
        end
        if (wr && wb_sel_i[0])
        begin
            case (wb_adr_i)
                ssc_pkg::OFS_MODE:
                begin
                    n.mode = wb_dat_i[ssc_pkg::MODE_SEL_LSB +: 3]; // [R2]
                    n.ext_clk = wb_dat_i[ssc_pkg::MODE_EXT_CLK]; // [R7] [R8]
                end
                ssc_pkg::OFS_CTRL0:
                begin
                    n.src_sel = wb_dat_i[ssc_pkg::C0_SRC_LSB +: 2];
                    n.rts_sel = wb_dat_i[ssc_pkg::C0_RTS_SEL];
                    n.hs_dis = wb_dat_i[ssc_pkg::C0_HS_DIS];
                    n.pol = wb_dat_i[ssc_pkg::C0_POL];
                    n.msb = wb_dat_i[ssc_pkg::C0_MSB];
                end
                ssc_pkg::OFS_CTRL1:
                begin
                    n.tx_en = wb_dat_i[ssc_pkg::C1_TX_EN];
                    n.rx_en = wb_dat_i[ssc_pkg::C1_RX_EN];
                    n.tx_cause = wb_dat_i[ssc_pkg::C1_TX_CAUSE];
                    n.cont_rx = wb_dat_i[ssc_pkg::C1_CONT_RX];
                    n.multi_clk = wb_dat_i[ssc_pkg::C1_MULTI_CLK] && (CHANNEL == 1);
                    n.clk_pin_sel = wb_dat_i[ssc_pkg::C1_CLK_PIN_SEL] && (CHANNEL == 1);
                end
                ssc_pkg::OFS_BRG: n.brg = wb_dat_i[7:0];
                ssc_pkg::OFS_TXBUF:
                begin
                    n.txbuf = wb_dat_i[7:0];
                    n.tx_empty = 1'b0; // [R9]
                end
                ssc_pkg::OFS_STATUS:
                begin
                    if (wb_dat_i[ssc_pkg::ST_COLL])
                    begin
                        n.coll_flag = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (wr && wb_sel_i[1] && (wb_adr_i == ssc_pkg::OFS_CTRL1))
        begin
            n.sep_hs = wb_dat_i[ssc_pkg::C1_SEP_HS] && (CHANNEL == 0); // [R19]
        end
        if (rd && (wb_adr_i == ssc_pkg::OFS_RXBUF))
        begin
            n.rx_full = 1'b0;
            n.overrun = 1'b0;
            n.rearm = q.cont_rx && q.rx_en; // [R17]
        end

        // hardware sets win over software clears
        if (n.rx_irq)
        begin
            n.rx_full = 1'b1; // [R13]
        end
        if ((q.fsm == ssc_pkg::SSC_SHIFT) && (n.fsm == ssc_pkg::SSC_IDLE) && q.rx_act
            && q.rx_full)
        begin
            n.overrun = 1'b1; // [R14]
        end
        if (n.coll_irq)
        begin
            n.coll_flag = 1'b1; // [R3]
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= '0;
            q.brg <= ssc_pkg::RST_BRG;
            q.brg_cnt <= ssc_pkg::RST_BRG;
            q.tx_empty <= 1'b1;
            q.fsm <= ssc_pkg::SSC_IDLE;
            q.clk_lvl <= 1'b1;
            q.clk_in_prev <= 1'b1;
            q.txd <= 1'b1; // [R21]
            q.clk_out <= 1'b1;
            q.clk2_out <= 1'b1;
            q.hs_out <= 1'b1;
            q.hs2_out <= 1'b1;
        end
        else
        begin
            q <= n;
        end
    end

    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign txd_out = q.txd;
    assign clk_pin_out = q.clk_out;
    assign clk_pin_oe = q.clk_oe;
    assign clk2_pin_out = q.clk2_out;
    assign clk2_pin_oe = q.clk2_oe;
    assign hs_pin_out = q.hs_out;
    assign hs_pin_oe = q.hs_oe;
    assign hs2_pin_out = q.hs2_out;
    assign hs2_pin_oe = q.hs2_oe;
    assign tx_irq = q.tx_irq;
    assign rx_irq = q.rx_irq;
    assign coll_irq = q.coll_irq;
endmodule

/* test/ssc_channel_asserts.sv */
// checker: port-level properties of the serial channel
`timescale 1ns/1ns
module ssc_channel_asserts #(
    parameter int CHANNEL = 0
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic txd_out,
    input wire logic clk_pin_out,
    input wire logic clk_pin_oe,
    input wire logic clk2_pin_oe,
    input wire logic tx_irq,
    input wire logic rx_irq,
    input wire logic coll_irq
);
    logic clk_prev_q;
    logic oe_prev_q;
    logic seen_q;
    logic [3:0] tog_q;
    logic tog;
    assign tog = clk_pin_oe && oe_prev_q && (clk_pin_out != clk_prev_q);
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            clk_prev_q <= 1'b1;
            oe_prev_q <= 1'b0;
            seen_q <= 1'b0;
            tog_q <= 4'h0;
        end
        else
        begin
            clk_prev_q <= clk_pin_out;
            oe_prev_q <= clk_pin_oe;
            seen_q <= seen_q | tog;
            tog_q <= tog_q + {3'h0, tog};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
    property p_txd_idle; !seen_q && !tog |-> txd_out; endproperty
    a_txd_idle: assert property (p_txd_idle) else $error("data low before first transfer");
    property p_frame; rx_irq |-> clk_pin_oe ? tog && tog_q == 4'hf : tog_q == 4'h0; endproperty
    a_frame: assert property (p_frame) else $error("receive not after sixteen edges");
    property p_edge; $changed(txd_out) && tog_q != 4'h0 |-> tog && !tog_q[0]; endproperty
    a_edge: assert property (p_edge) else $error("data changed off the leaving edge");
    property p_tx_pulse; tx_irq |=> !tx_irq; endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("transmit request too long");
    property p_rx_pulse; rx_irq |=> !rx_irq; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("receive request too long");
    property p_coll; CHANNEL != 2 |-> !coll_irq; endproperty
    a_coll: assert property (p_coll) else $error("collision on a channel without it");
    property p_clk2; CHANNEL != 1 |-> !clk2_pin_oe; endproperty
    a_clk2: assert property (p_clk2) else $error("second clock pin driven");
endmodule

/* test/ssc_peer.sv */
// partner: clock-synchronous peer that shifts one byte each way
`timescale 1ns/1ns
module ssc_peer (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic txd,
    input wire logic pol,
    input wire logic msb,
    input wire logic [7:0] out_byte,
    output logic rxd,
    output logic [7:0] got_byte
);
    logic prev_q;
    logic busy_q;
    logic [2:0] n_q;
    logic [7:0] sh_q;
    logic [7:0] nxt;
    assign nxt = msb ? {sh_q[6:0], txd} : {txd, sh_q[7:1]};
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            prev_q <= 1'b1;
            busy_q <= 1'b0;
            n_q <= 3'h0;
            sh_q <= 8'h00;
            rxd <= 1'b1;
            got_byte <= 8'h00;
        end
        else
        begin
            prev_q <= sclk;
            if (sclk != prev_q && sclk == pol) // leaving idle: next bit out
            begin
                busy_q <= 1'b1;
                rxd <= msb ? out_byte[3'h7 - n_q] : out_byte[n_q];
            end
            else if (sclk != prev_q && busy_q) // returning: sample
            begin
                sh_q <= nxt;
                n_q <= n_q + 3'h1;
                if (n_q == 3'h7)
                begin
                    busy_q <= 1'b0;
                    got_byte <= nxt;
                end
            end
            else if (!busy_q)
                rxd <= ~rxd; // released line shows no stale level
        end
    end
endmodule

/* test/ssc_channel_tb_top.sv */
// testbench: random and corner transfers through the serial channel
`timescale 1ns/1ns
module ssc_channel_tb_top;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic hs_pin_in = 1'b1;
    logic peer_pol = 1'b0;
    logic peer_msb = 1'b0;
    logic [7:0] peer_b = 8'h00;
    logic [31:0] wb_dat_o;
    logic [7:0] got_b;
    logic wb_ack_o, txd_out, rxd_in, clk_pin_in, clk_pin_out, clk_pin_oe, clk2_pin_out;
    logic clk2_pin_oe, hs_pin_out, hs_pin_oe, hs2_pin_out, hs2_pin_oe, tx_irq, rx_irq, coll_irq;
    logic clk_prev = 1'b1;
    logic oe_prev = 1'b0;
    logic ext_sclk = 1'b1;
    logic [31:0] seed = 32'hff79_669e;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc_n = 0, tog_n = 0, tx_n = 0, rx_n = 0, t_tog = 0, t_tog1 = 0, t_tx = 0;
    assign clk_pin_in = clk_pin_oe ? clk_pin_out : ext_sclk ^ peer_pol;
    ssc_channel #(.CHANNEL(0)) i_dut (.clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_out(txd_out),
        .rxd_in(rxd_in), .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out),
        .clk_pin_oe(clk_pin_oe), .clk2_pin_out(clk2_pin_out), .clk2_pin_oe(clk2_pin_oe),
        .hs_pin_in(hs_pin_in), .hs_pin_out(hs_pin_out), .hs_pin_oe(hs_pin_oe),
        .hs2_pin_in(1'b1), .hs2_pin_out(hs2_pin_out), .hs2_pin_oe(hs2_pin_oe),
        .tx_irq(tx_irq), .rx_irq(rx_irq), .coll_irq(coll_irq));
    ssc_peer i_peer (.clock(clock), .resetn(resetn), .sclk(clk_pin_in), .txd(txd_out),
        .pol(peer_pol), .msb(peer_msb), .out_byte(peer_b), .rxd(rxd_in), .got_byte(got_b));
    initial forever #10 clock = ~clock;
    initial
    begin
        #1_000_000;
        error_cnt++;
        end_sim();
    end
    always @(posedge clock)
    begin
        cyc_n <= cyc_n + 1;
        clk_prev <= clk_pin_out;
        oe_prev <= clk_pin_oe;
        if (clk_pin_oe && oe_prev && clk_pin_out !== clk_prev)
        begin
            tog_n <= tog_n + 1;
            t_tog <= cyc_n;
            if (tog_n % 16 == 0)
                t_tog1 <= cyc_n;
        end
        if (tx_irq === 1'b1)
        begin
            tx_n <= tx_n + 1;
            t_tx <= cyc_n;
        end
        if (rx_irq === 1'b1)
            rx_n <= rx_n + 1;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int hp(input logic [1:0] s, input logic [7:0] b);
        return (b + 1) * (s == ssc_pkg::SRC_F1 ? 1 : (s == ssc_pkg::SRC_F8 ? 8 : 32));
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge clock); while (wb_ack_o !== 1'b1 && ++n < 50);
        if (n >= 50)
            error_cnt++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic cfg(input logic [7:0] c0, input logic [8:0] c1, input logic [7:0] b);
        logic [31:0] q;
        wb(1'b1, ssc_pkg::OFS_MODE, 32'h0, q);
        wb(1'b1, ssc_pkg::OFS_CTRL0, {24'h0, c0}, q);
        peer_pol <= c0[ssc_pkg::C0_POL];
        peer_msb <= c0[ssc_pkg::C0_MSB];
        wb(1'b1, ssc_pkg::OFS_CTRL1, {23'h0, c1}, q);
        wb(1'b1, ssc_pkg::OFS_BRG, {24'h0, b}, q);
        wb(1'b1, ssc_pkg::OFS_MODE, {29'h0, ssc_pkg::MODE_SYNC}, q);
    endtask
    task automatic xfer(input logic wr, input logic [7:0] tb_b, input logic [7:0] pb,
        input int erx, input int cause, input int h, input int cts);
        int n0, r0, x0, k;
        logic [31:0] q;
        n0 = tog_n;
        r0 = rx_n;
        x0 = tx_n;
        peer_b <= pb;
        if (wr)
            wb(1'b1, ssc_pkg::OFS_TXBUF, {24'h0, tb_b}, q);
        else
            wb(1'b0, ssc_pkg::OFS_RXBUF, 32'h0, q);
        if (cts)
        begin
            repeat (40) @(posedge clock);
            chk(tog_n - n0, 0);
            chk({31'h0, hs_pin_oe}, 32'h0);
            hs_pin_in <= 1'b0;
        end
        k = 0;
        while (tog_n < n0 + 16 && k < 20000)
        begin
            @(posedge clock);
            k++;
        end
        repeat (4) @(posedge clock);
        chk(tog_n - n0, 16);
        chk(t_tog - t_tog1, 15 * h);
        chk({24'h0, got_b}, {24'h0, tb_b});
        chk(rx_n - r0, erx);
        chk({31'h0, clk_pin_out}, {31'h0, ~peer_pol});
        if (wr)
            chk(tx_n - x0 == 1 && (cause ? t_tx >= t_tog : t_tx < t_tog1), 1);
    endtask
    initial
    begin
        logic [31:0] q, r;
        logic [7:0] brg;
        logic [1:0] src;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        wb(1'b0, ssc_pkg::OFS_STATUS, 32'h0, q);
        chk(q, 32'h0000_0006);
        wb(1'b0, 8'h1c, 32'h0, q);
        chk(q, 32'h0000_0000);
        for (int i = 0; i < 6; i++)
        begin
            r = rnd();
            src = 2'(i % 3);
            brg = 8'h02 + {6'h0, r[5:4]};
            hs_pin_in <= r[24];
            cfg({i[1], i[0], 2'b01, 2'b00, src}, {4'h0, i > 2, 1'b0, i != 4, 2'b01}, brg);
            xfer(1'b1, r[15:8], r[23:16], i != 4, i > 2, hp(src, brg), 0);
            wb(1'b0, (i != 4) ? ssc_pkg::OFS_RXBUF : ssc_pkg::OFS_STATUS, 32'h0, q);
            chk((i != 4) ? q : {31'h0, q[0]}, (i != 4) ? {24'h0, r[23:16]} : 32'h0);
        end
        r = rnd();
        cfg(8'h00, 9'h005, 8'h02);
        wb(1'b1, ssc_pkg::OFS_CTRL0, 32'h0000_0004, q);
        @(posedge clock);
        chk({30'h0, hs_pin_oe, hs_pin_out}, 32'h0000_0002);
        wb(1'b1, ssc_pkg::OFS_CTRL0, 32'h0000_0000, q);
        hs_pin_in <= 1'b1;
        xfer(1'b1, r[7:0], r[15:8], 1, 0, 3, 1);
        xfer(1'b1, r[23:16], r[31:24], 0, 0, 3, 0);
        wb(1'b0, ssc_pkg::OFS_RXBUF, 32'h0, q);
        chk(q, {23'h0, 1'b1, r[31:24]});
        r = rnd();
        peer_b <= r[15:8];
        wb(1'b1, ssc_pkg::OFS_MODE, 32'h0000_0009, q);
        wb(1'b1, ssc_pkg::OFS_TXBUF, {24'h0, r[7:0]}, q);
        repeat (16)
        begin
            repeat (4) @(posedge clock);
            ext_sclk <= ~ext_sclk;
        end
        repeat (4) @(posedge clock);
        chk({24'h0, got_b}, {24'h0, r[7:0]});
        wb(1'b0, ssc_pkg::OFS_RXBUF, 32'h0, q);
        chk(q, {24'h0, r[15:8]});
        wb(1'b1, ssc_pkg::OFS_MODE, {29'h0, ssc_pkg::MODE_SYNC}, q);
        wb(1'b1, ssc_pkg::OFS_CTRL1, 32'h0000_0025, q);
        xfer(1'b0, 8'hff, 8'h5a, 1, 0, 3, 0);
        wb(1'b0, ssc_pkg::OFS_RXBUF, 32'h0, q);
        chk(q, 32'h0000_005a);
        end_sim();
    end
endmodule
bind ssc_channel ssc_channel_asserts #(.CHANNEL(CHANNEL)) i_chk (.clock(clock),
    .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .txd_out(txd_out), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .clk2_pin_oe(clk2_pin_oe), .tx_irq(tx_irq), .rx_irq(rx_irq), .coll_irq(coll_irq));
